// file: verilog/dcc_top.sv
// Overview of operation
// - a conversion takes 13 periods of the conversion clock
// - trigger fall well before a rising edge starts conversion on that edge
// - trigger fall just after an edge starts conversion on the next edge
// - a trigger change near an edge may start on either edge
// - busy rises after trigger fall, except in automatic nap mode
// - busy falls after the 14th rising clock edge of the conversion
// - both converters sample together and convert together on one trigger
// - each converter has its own multiplexer, 2:1 in differential use
// - pseudo-differential 3:1 mode uses pair 0 inverting as common input
// - select bits 00 route pair 0, 11 route pair 1
// - reference output level comes from a 10-bit code, 2.44mV steps
// - a write strobe loads data from the parallel bus
// - trigger fall holds inputs at once, conversion starts next rise
// - 12 convert cycles, one precharge, three sample, 16 clocks per cycle
`timescale 1ns/1ps
`default_nettype none
module dcc_top #(
   parameter int FIFO_DEPTH = 16
) (
   // system clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   // conversion pins
   input  wire logic        conv_clk_i,
   input  wire logic        conversion_trigger_n_i,
   input  wire logic        nap_mode_i,
   // parallel bus pins
   input  wire logic        chip_select_n_i,
   input  wire logic        read_n_i,
   input  wire logic        write_n_i,
   input  wire logic [11:0] db_i,
   output logic      [11:0] db_o,
   output logic             db_oe_o,
   // comparator decisions from both converters
   input  wire logic        cmp_a_i,
   input  wire logic        cmp_b_i,
   // converter control
   output logic             busy_o,
   output logic             hold_o,
   output logic             precharge_o,
   output logic      [11:0] trial_a_o,
   output logic      [11:0] trial_b_o,
   // multiplexer routing for both converters
   output logic      [1:0]  mux_a_pos_sel_o,
   output logic      [1:0]  mux_a_neg_sel_o,
   output logic      [1:0]  mux_b_pos_sel_o,
   output logic      [1:0]  mux_b_neg_sel_o,
   output logic             pseudo_diff_o,
   // reference level
   output logic      [9:0]  reference_code_o,
   // status
   output logic             acq_short_o,
   output logic             overrun_o
);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisation

   localparam int NPIN = 20;

   logic [NPIN-1:0] pins_sync;
   logic            s_clk;
   logic            s_trig_n;
   logic            s_nap;
   logic            s_cs_n;
   logic            s_rd_n;
   logic            s_wr_n;
   logic [11:0]     s_db;
   logic            s_cmp_a;
   logic            s_cmp_b;

   // every pin passes two flops; the data word is synchronised alongside
   // the write strobe so both arrive with the same delay
   dcc_sync #(
      .W (NPIN)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .pin_i     ({conv_clk_i, conversion_trigger_n_i, nap_mode_i,
                   chip_select_n_i, read_n_i, write_n_i, db_i,
                   cmp_a_i, cmp_b_i}),
      .sync_o    (pins_sync)
   );

   assign {s_clk, s_trig_n, s_nap, s_cs_n, s_rd_n, s_wr_n, s_db,
           s_cmp_a, s_cmp_b} = pins_sync;

   ////////////////////////////////////////////////////////////////////////
   // edge detection

   logic d_clk;
   logic d_trig_n;
   logic d_rd_n;
   logic d_wr_n;
   logic clk_rise;
   logic trig_fall;
   logic rd_fall;
   logic wr_rise;

   // delayed copies reset to the synchroniser's ones, else reset release
   // would look like a rising edge of the conversion clock
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         d_clk    <= 1'b1;
         d_trig_n <= 1'b1;
         d_rd_n   <= 1'b1;
         d_wr_n   <= 1'b1;
      end else begin
         d_clk    <= s_clk;
         d_trig_n <= s_trig_n;
         d_rd_n   <= s_rd_n;
         d_wr_n   <= s_wr_n;
      end
   end

   // trigger and clock see the same delay, so their order is kept; close
   // to an edge the synchroniser decides which comes first
   assign clk_rise  = s_clk && !d_clk;
   assign trig_fall = !s_trig_n && d_trig_n;
   assign rd_fall   = !s_rd_n && d_rd_n && !s_cs_n;
   assign wr_rise   = s_wr_n && !d_wr_n && !s_cs_n;

   ////////////////////////////////////////////////////////////////////////
   // conversion sequence

   dcc_pkg::dcc_state_type state;
   logic [3:0]             edge_cnt;
   logic [11:0]            res_a;
   logic [11:0]            res_b;
   logic                   res_valid;
   logic                   fifo_in_ready;
   logic                   start_ok;
   logic [3:0]             bit_idx;

   // a start is refused while a finished result still waits for space
   assign start_ok = !res_valid;
   // bit decided by the edge that follows edge edge_cnt
   assign bit_idx  = 4'(dcc_pkg::LAST_BIT_EDGE - 1) - edge_cnt;

   // set the decided bit, try the next lower one
   function automatic logic [11:0] sar_step(input logic [11:0] t,
                                            input logic [3:0]  idx,
                                            input logic        keep);
      logic [11:0] r;
      r      = t;
      r[idx] = keep;
      if (idx != 4'h0) begin
         r[idx - 4'h1] = 1'b1;
      end
      return r;
   endfunction

   // state and edge counting on the conversion clock
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state    <= dcc_pkg::DCC_SAMPLE;
         edge_cnt <= 4'h0;
      end else begin
         case (state)
            dcc_pkg::DCC_SAMPLE: begin
               if (trig_fall && start_ok) begin
                  state <= dcc_pkg::DCC_WAIT_EDGE;
               end
            end
            dcc_pkg::DCC_WAIT_EDGE: begin
               if (clk_rise) begin
                  state    <= dcc_pkg::DCC_CONVERT;
                  edge_cnt <= 4'h1;
               end
            end
            dcc_pkg::DCC_CONVERT: begin
               if (clk_rise) begin
                  edge_cnt <= edge_cnt + 4'h1;
                  // last bit decided: one precharge cycle follows
                  if (edge_cnt == 4'(dcc_pkg::LAST_BIT_EDGE - 1)) begin
                     state <= dcc_pkg::DCC_PRECHARGE;
                  end
               end
            end
            dcc_pkg::DCC_PRECHARGE: begin
               if (clk_rise) begin
                  // this is edge 14: 13 periods after the start edge
                  state    <= dcc_pkg::DCC_SAMPLE;
                  edge_cnt <= 4'h0;
               end
            end
            default: begin
               state    <= dcc_pkg::DCC_SAMPLE;
               edge_cnt <= 4'h0;
            end
         endcase
      end
   end

   // successive approximation on both converters in lockstep
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trial_a_o <= dcc_pkg::TRIAL_RESET;
         trial_b_o <= dcc_pkg::TRIAL_RESET;
      end else if (state == dcc_pkg::DCC_WAIT_EDGE) begin
         trial_a_o <= dcc_pkg::TRIAL_RESET;
         trial_b_o <= dcc_pkg::TRIAL_RESET;
      end else if (state == dcc_pkg::DCC_CONVERT && clk_rise) begin
         trial_a_o <= sar_step(trial_a_o, bit_idx, s_cmp_a);
         trial_b_o <= sar_step(trial_b_o, bit_idx, s_cmp_b);
      end
   end

   // hold, busy and precharge levels
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_o      <= 1'b0;
         busy_o      <= 1'b0;
         precharge_o <= 1'b0;
      end else begin
         case (state)
            dcc_pkg::DCC_SAMPLE: begin
               if (trig_fall && start_ok) begin
                  hold_o <= 1'b1; // both inputs held at once
                  busy_o <= !s_nap;
               end
            end
            dcc_pkg::DCC_WAIT_EDGE: begin
               // in nap mode busy waits for the start edge
               if (clk_rise) begin
                  busy_o <= 1'b1;
               end
            end
            dcc_pkg::DCC_CONVERT: begin
               if (clk_rise &&
                   edge_cnt == 4'(dcc_pkg::LAST_BIT_EDGE - 1)) begin
                  precharge_o <= 1'b1;
               end
            end
            dcc_pkg::DCC_PRECHARGE: begin
               if (clk_rise) begin
                  busy_o      <= 1'b0;
                  hold_o      <= 1'b0;
                  precharge_o <= 1'b0;
               end
            end
            default: begin
               hold_o      <= 1'b0;
               busy_o      <= 1'b0;
               precharge_o <= 1'b0;
            end
         endcase
      end
   end

   // finished result waits here until the buffer takes it
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         res_valid <= 1'b0;
         res_a     <= 12'h000;
         res_b     <= 12'h000;
      end else if (state == dcc_pkg::DCC_CONVERT && clk_rise &&
                   edge_cnt == 4'(dcc_pkg::LAST_BIT_EDGE - 1)) begin
         res_valid <= 1'b1;
         res_a     <= sar_step(trial_a_o, bit_idx, s_cmp_a);
         res_b     <= sar_step(trial_b_o, bit_idx, s_cmp_b);
      end else if (res_valid && fifo_in_ready) begin
         res_valid <= 1'b0;
      end
   end

   // refused trigger reported until the next accepted one
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         overrun_o <= 1'b0;
      end else if (trig_fall && state == dcc_pkg::DCC_SAMPLE) begin
         overrun_o <= !start_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // acquisition check

   logic [1:0] acq_edges;
   logic [4:0] acq_cyc;

   // count sample edges and system cycles since the switches closed;
   // too short a sample only shows as a flag, the host owns the timing
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acq_edges   <= 2'h3;
         acq_cyc     <= 5'(dcc_pkg::ACQ_CYC);
         acq_short_o <= 1'b0;
      end else if (state == dcc_pkg::DCC_SAMPLE) begin
         if (clk_rise && acq_edges != 2'h3) begin
            acq_edges <= acq_edges + 2'h1;
         end
         if (acq_cyc != 5'(dcc_pkg::ACQ_CYC)) begin
            acq_cyc <= acq_cyc + 5'h01;
         end
         if (trig_fall && start_ok) begin
            acq_short_o <= (acq_edges < 2'(dcc_pkg::MIN_SAMPLE_EDGES)) ||
                           (acq_cyc != 5'(dcc_pkg::ACQ_CYC));
         end
      end else begin
         acq_edges <= 2'h0;
         acq_cyc   <= 5'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // parallel write: configuration and reference code

   logic [11:0] cfg;

   // a word with the top bits set loads the reference code
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg              <= dcc_pkg::CFG_RESET;
         reference_code_o <= dcc_pkg::REF_RESET;
      end else if (wr_rise) begin
         if (s_db[11:dcc_pkg::CMD_LSB] == dcc_pkg::CMD_REF) begin
            reference_code_o <= s_db[9:0];
         end else begin
            cfg <= s_db;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // input multiplexers

   logic       sel_hi;
   logic       sel_lo;
   logic [1:0] next_pos;
   logic [1:0] next_neg;

   assign sel_hi = cfg[dcc_pkg::CSEL_HI];
   assign sel_lo = cfg[dcc_pkg::CSEL_LO];

   // routing table for both select bits
   always_comb begin
      next_neg = dcc_pkg::IN_P0_INV;
      case ({sel_hi, sel_lo})
         2'b00:   next_pos = dcc_pkg::IN_P0_NONINV;
         2'b11: begin
            next_pos = dcc_pkg::IN_P1_NONINV;
            next_neg = dcc_pkg::IN_P1_INV;
         end
         2'b01:   next_pos = dcc_pkg::IN_P1_INV;
         default: next_pos = dcc_pkg::IN_P1_NONINV;
      endcase
   end

   // routing changes only while sampling, never under a held input;
   // both converters get their own copy of the same routing
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mux_a_pos_sel_o <= dcc_pkg::IN_P0_NONINV;
         mux_a_neg_sel_o <= dcc_pkg::IN_P0_INV;
         mux_b_pos_sel_o <= dcc_pkg::IN_P0_NONINV;
         mux_b_neg_sel_o <= dcc_pkg::IN_P0_INV;
         pseudo_diff_o   <= 1'b0;
      end else if (state == dcc_pkg::DCC_SAMPLE) begin
         mux_a_pos_sel_o <= next_pos;
         mux_a_neg_sel_o <= next_neg;
         mux_b_pos_sel_o <= next_pos;
         mux_b_neg_sel_o <= next_neg;
         pseudo_diff_o   <= sel_hi ^ sel_lo;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result buffer and parallel read

   logic        fifo_out_valid;
   logic [23:0] fifo_out_data;
   logic        pop;
   logic        half_b;

   dcc_fifo #(
      .W     (24),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i   (sys_clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (res_valid),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   ({res_a, res_b}),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (pop),
      .out_data_o  (fifo_out_data)
   );

   // first read gives converter a, second gives b and frees the entry
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         db_o   <= 12'h000;
         half_b <= 1'b0;
         pop    <= 1'b0;
      end else begin
         pop <= 1'b0;
         if (rd_fall) begin
            if (!fifo_out_valid) begin
               db_o <= 12'h000; // buffer empty, no unread result
            end else if (!half_b) begin
               db_o   <= fifo_out_data[23:12];
               half_b <= 1'b1;
            end else begin
               db_o   <= fifo_out_data[11:0];
               half_b <= 1'b0;
               pop    <= 1'b1;
            end
         end
      end
   end

   // drive the data pins while selected and reading
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         db_oe_o <= 1'b0;
      end else begin
         db_oe_o <= !s_cs_n && !s_rd_n;
      end
   end

endmodule
`default_nettype wire

// file: inc/dcc_pkg.sv
// shared constants of the dual converter conversion control
package dcc_pkg;

   // result and reference widths
   localparam int RES_BITS  = 12;
   localparam int REF_BITS  = 10;

   // conversion clock edge counts, start edge counted as edge 1
   localparam int CONV_PERIODS   = 13;
   localparam int LAST_BIT_EDGE  = 13;
   localparam int BUSY_END_EDGE  = 14;
   localparam int MIN_SAMPLE_EDGES = 2;
   localparam int MIN_CYCLE_CLKS = 16;

   // acquisition time and its system clock count (least time, round up)
   localparam int SYS_PERIOD_PS = 4000;
   localparam int ACQ_TIME_PS   = 62500;
   localparam int ACQ_CYC       = (ACQ_TIME_PS + SYS_PERIOD_PS - 1)
                                  / SYS_PERIOD_PS;

   // reference step in microvolts per code
   localparam int REF_STEP_UV = 2440;

   // reset values
   localparam logic [11:0] CFG_RESET = 12'h000;
   localparam logic [9:0]  REF_RESET = 10'h3FF;
   localparam logic [11:0] TRIAL_RESET = 12'h800;

   // parallel write word layout
   localparam int          CMD_LSB  = 10;
   localparam logic [1:0]  CMD_REF  = 2'h3;
   localparam int          CSEL_LO  = 0;
   localparam int          CSEL_HI  = 1;

   // multiplexer input codes
   localparam logic [1:0]  IN_P0_NONINV = 2'h0;
   localparam logic [1:0]  IN_P0_INV    = 2'h1;
   localparam logic [1:0]  IN_P1_NONINV = 2'h2;
   localparam logic [1:0]  IN_P1_INV    = 2'h3;

   // conversion sequence states
   typedef enum logic [1:0] {
      DCC_SAMPLE,
      DCC_WAIT_EDGE,
      DCC_CONVERT,
      DCC_PRECHARGE
   } dcc_state_type;

endpackage

// file: verilog/dcc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two flip-flop synchroniser for pin inputs
module dcc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         rst_n_i,
   // pin side and synchronised side
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta;

   // first stage is read only by the second stage; resets to ones since
   // strobes and trigger idle high, so release shows them no false edge
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta   <= '1;
         sync_o <= '1;
      end else begin
         meta   <= pin_i;
         sync_o <= meta;
      end
   end

endmodule
`default_nettype wire

// file: verilog/dcc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// result buffer between conversion and parallel read
module dcc_fifo #(
   parameter int W     = 24,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         rst_n_i,
   // filling side
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // draining side
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic      [W-1:0] out_data_o
);

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wptr;
   logic [AW:0]  rptr;
   logic         push;
   logic         pop;

   // full when pointers differ only in the wrap bit
   assign in_ready_o  = !((wptr[AW] != rptr[AW]) &&
                          (wptr[AW-1:0] == rptr[AW-1:0]));
   assign out_valid_o = (wptr != rptr);
   assign out_data_o  = mem[rptr[AW-1:0]];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // storage, no reset needed on the data
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[wptr[AW-1:0]] <= in_data_i;
      end
   end

   // pointers
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wptr <= '0;
         rptr <= '0;
      end else begin
         if (push) begin
            wptr <= wptr + 1'b1;
         end
         if (pop) begin
            rptr <= rptr + 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// file: testbench/dcc_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// timing and routing checks on the top ports
module dcc_chk (
   // clock, reset and pins
   input wire logic       sys_clk_i,
   input wire logic       rst_n_i,
   input wire logic       conv_clk_i,
   input wire logic       conversion_trigger_n_i,
   input wire logic       nap_mode_i,
   // status and routing
   input wire logic       busy_o,
   input wire logic       hold_o,
   input wire logic       precharge_o,
   input wire logic       overrun_o,
   input wire logic       pseudo_diff_o,
   input wire logic [1:0] mux_a_pos_sel_o,
   input wire logic [1:0] mux_a_neg_sel_o,
   input wire logic [1:0] mux_b_pos_sel_o,
   input wire logic [1:0] mux_b_neg_sel_o
);
   logic [4:0] cnt;
   logic       ck_q;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // pin rises since the last trigger seen with hold low; saturates so idle never wraps
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= 5'h00;
         ck_q <= 1'b0;
      end else begin
         ck_q <= conv_clk_i;
         if ($fell(conversion_trigger_n_i) && !hold_o)
            cnt <= 5'h00;
         else if (conv_clk_i && !ck_q && cnt != 5'h1F)
            cnt <= cnt + 5'h01;
      end
   end
   hold_start_a:
      assert property ($fell(conversion_trigger_n_i) && !hold_o |->
         ##[3:5] (hold_o || overrun_o)) else $error("hold late");
   busy_hold_a:
      assert property (!nap_mode_i && $rose(hold_o) |-> busy_o)
         else $error("busy late");
   nap_busy_a:
      assert property (nap_mode_i && $rose(hold_o) && cnt == 5'h00
         |-> !busy_o) else $error("busy early in nap");
   hold_len_a:
      assert property (hold_o && cnt < 5'h0E |=> hold_o)
         else $error("hold short");
   prech_edge_a:
      assert property ($rose(precharge_o) |-> cnt == 5'h0D)
         else $error("precharge edge");
   conv_end_a:
      assert property ($fell(hold_o) |-> cnt == 5'h0E && !busy_o
         && !precharge_o) else $error("end edge");
   diff_route_a:
      assert property (!pseudo_diff_o |-> !mux_a_pos_sel_o[0]
         && mux_a_neg_sel_o == mux_a_pos_sel_o + 2'h1)
         else $error("diff route");
   common_input_a:
      assert property (pseudo_diff_o |-> mux_a_neg_sel_o == 2'h1
         && mux_a_pos_sel_o != 2'h1) else $error("common input");
   pair_route_a:
      assert property (mux_b_pos_sel_o == mux_a_pos_sel_o
         && mux_b_neg_sel_o == mux_a_neg_sel_o) else $error("pair route");
   cover property ($rose(precharge_o));
   cover property ($rose(pseudo_diff_o));
   cover property ($rose(overrun_o));
endmodule
bind dcc_top dcc_chk u_chk (.sys_clk_i, .rst_n_i, .conv_clk_i,
   .conversion_trigger_n_i, .nap_mode_i, .busy_o, .hold_o, .precharge_o,
   .overrun_o, .pseudo_diff_o, .mux_a_pos_sel_o, .mux_a_neg_sel_o,
   .mux_b_pos_sel_o, .mux_b_neg_sel_o);
`default_nettype wire

// file: testbench/dcc_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side: conversion clock, trigger and parallel strobes
module dcc_host (
   // clock and design status
   input wire logic        clk_i,
   input wire logic        busy_i,
   input wire logic        hold_i,
   input wire logic        oe_i,
   input wire logic [11:0] rd_data_i,
   // pins toward the design
   output logic            conv_clk_o,
   output logic            trig_n_o,
   output logic            cs_n_o,
   output logic            rd_n_o,
   output logic            wr_n_o,
   output logic     [11:0] wr_data_o
);
   logic [1:0] seen; // busy and hold just after a trigger
   // idle levels; the clock stands low between frames
   initial begin
      {conv_clk_o, trig_n_o, cs_n_o, rd_n_o, wr_n_o} = 5'h0F;
      wr_data_o = 12'h5A5;
   end
   // one frame of n periods at 31.25 MHz, then gap cycles
   task automatic convert(input int n, input int gap);
      @(negedge clk_i);
      trig_n_o = 1'b0;
      repeat (4) @(negedge clk_i); // 16 ns ahead of the rise
      for (int i = 0; i < n; i++) begin
         conv_clk_o = 1'b1;
         @(negedge clk_i);
         if (i == 0) seen = {busy_i, hold_i};
         repeat (3) @(negedge clk_i);
         conv_clk_o = 1'b0;
         if (i == 0) trig_n_o = 1'b1; // at the falling clock edge
         repeat (4) @(negedge clk_i);
      end
      repeat (gap) @(negedge clk_i); // acquisition time
   endtask
   // stray trigger pulse, used only to break the busy rule on purpose
   task automatic poke();
      trig_n_o = 1'b0;
      repeat (8) @(negedge clk_i);
      trig_n_o = 1'b1;
   endtask
   // write: data stays put until well after the rising strobe
   task automatic write(input logic [11:0] w);
      @(negedge clk_i);
      {cs_n_o, wr_n_o} = 2'h0;
      wr_data_o = w;
      repeat (3) @(negedge clk_i);
      wr_n_o = 1'b1;
      repeat (4) @(negedge clk_i);
      cs_n_o = 1'b1;
      wr_data_o = ~w; // a released bus must not show the old word
      repeat (2) @(negedge clk_i);
   endtask
   // read: take the word once the drive delay has passed; reads run only
   // between frames, well ahead of the next busy rise
   task automatic read(output logic [11:0] d, output logic oe);
      @(negedge clk_i);
      {cs_n_o, rd_n_o} = 2'h0;
      repeat (5) @(negedge clk_i);
      d = rd_data_i;
      oe = oe_i;
      {cs_n_o, rd_n_o} = 2'h3;
      repeat (4) @(negedge clk_i);
   endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the conversion control
module testbench;
   typedef struct packed {
      logic [11:0] w;
      logic [1:0]  pos;
      logic [1:0]  neg;
      logic        pd;
      logic [9:0]  rf;
   } dcc_row_type;
   logic        sys_clk = 1'b0;
   logic        rst_n, nap, cmp_a, cmp_b, oe_seen;
   logic        conv_clk, trig_n, cs_n, rd_n, wr_n, busy, hold, oe;
   logic        pd, ovr, acq, pre;
   logic [1:0]  apos, aneg;
   logic [9:0]  refc;
   logic [11:0] wdata, rdata, trial, trb, d, e;
   int          num_errors = 0;
   int          n_checks = 0;
   // config words against routing and reference they should give
   dcc_row_type rows [7] = '{
      '{12'h000, 2'h0, 2'h1, 1'b0, 10'h3FF},
      '{12'h003, 2'h2, 2'h3, 1'b0, 10'h3FF},
      '{12'h001, 2'h3, 2'h1, 1'b1, 10'h3FF},
      '{12'h002, 2'h2, 2'h1, 1'b1, 10'h3FF},
      '{12'hCCD, 2'h2, 2'h1, 1'b1, 10'h0CD},
      '{12'hDFD, 2'h2, 2'h1, 1'b1, 10'h1FD},
      '{12'h000, 2'h0, 2'h1, 1'b0, 10'h1FD}};
   ////////////////////////////////////////////////////////////////////
   dcc_top #(.FIFO_DEPTH(16)) uut (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
      .conv_clk_i(conv_clk), .conversion_trigger_n_i(trig_n),
      .nap_mode_i(nap), .chip_select_n_i(cs_n), .read_n_i(rd_n),
      .write_n_i(wr_n), .db_i(wdata), .db_o(rdata), .db_oe_o(oe),
      .cmp_a_i(cmp_a), .cmp_b_i(cmp_b), .busy_o(busy), .hold_o(hold),
      .precharge_o(pre), .trial_a_o(trial), .trial_b_o(trb),
      .mux_a_pos_sel_o(apos), .mux_a_neg_sel_o(aneg),
      .mux_b_pos_sel_o(), .mux_b_neg_sel_o(), .pseudo_diff_o(pd),
      .reference_code_o(refc), .acq_short_o(acq), .overrun_o(ovr));
   dcc_host host (.clk_i(sys_clk), .busy_i(busy), .hold_i(hold),
      .oe_i(oe), .rd_data_i(rdata), .conv_clk_o(conv_clk),
      .trig_n_o(trig_n), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
      .wr_data_o(wdata));
   // 250 MHz system clock
   always #2 sys_clk = ~sys_clk;
   // compare one state word; unknown bits never match
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // single place where the run ends
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog: the whole sequence needs well under 8000 cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      stop_test();
   end
   // main sequence
   initial begin
      {rst_n, nap, cmp_a, cmp_b} = 4'h2;
      repeat (4) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk({busy, hold, pre, ovr, acq, pd, refc}, 16'h03FF);
      chk({apos, aneg, trial}, 16'h1800);
      chk({4'h0, trb}, 16'h0800);
      host.read(d, oe_seen);
      chk({3'h0, oe_seen, d}, 16'h1000);
      foreach (rows[i]) begin
         host.write(rows[i].w);
         chk({1'b0, apos, aneg, pd, refc}, {1'b0, rows[i][14:0]});
      end
      // a trigger during a conversion must leave one result only
      fork
         host.convert(16, 24);
         begin
            repeat (22) @(negedge sys_clk);
            host.poke();
         end
      join
      chk({14'h0000, host.seen}, 16'h0003);
      host.read(d, oe_seen);
      host.read(e, oe_seen);
      chk({4'h0, d ^ e}, 16'h0FFF);
      host.read(d, oe_seen);
      chk({4'h0, d}, 16'h0000);
      // back-to-back frames: the second starts with too little sampling
      host.convert(14, 0);
      host.convert(16, 24);
      chk({15'h0000, acq}, 16'h0001);
      host.convert(16, 24);
      chk({15'h0000, acq}, 16'h0000);
      // nap mode holds the inputs but keeps busy low at the trigger
      nap = 1'b1;
      host.convert(16, 24);
      nap = 1'b0;
      chk({14'h0000, host.seen}, 16'h0001);
      // sixteen stored plus one waiting, then the next trigger is refused
      for (int i = 0; i < 13; i++)
         host.convert(16, 24);
      chk({15'h0000, ovr}, 16'h0000);
      host.convert(16, 24);
      chk({15'h0000, ovr}, 16'h0001);
      host.read(d, oe_seen);
      host.read(e, oe_seen);
      host.convert(16, 24);
      chk({15'h0000, ovr}, 16'h0000);
      for (int i = 0; i < 17; i++) begin
         host.read(d, oe_seen);
         host.read(e, oe_seen);
         chk({4'h0, d ^ e}, 16'h0FFF);
      end
      host.read(d, oe_seen);
      chk({3'h0, oe_seen, d}, 16'h1000);
      stop_test();
   end
endmodule
`default_nettype wire
